// >>> hdl/gcr_disk_data_codec.sv
// Group-code disk data path: write serialiser, read recovery, zones, speed
module gcr_disk_data_codec
  import gcr_codec_pkg::*;
#(
  parameter int unsigned TACH_BASE = TACH_BASE_CYC,
  parameter int unsigned TACH_STEP = TACH_STEP_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire logic       wr_start_i,
  input  wire logic       wr_field_i,
  input  wire logic [7:0] wr_byte_i,
  input  wire logic       wr_valid_i,
  output logic            wr_ready_o,
  output logic            wr_busy_o,
  input  wire logic       wr_prot_i,
  output logic            wr_gate_o,
  output logic            wr_data_o,
  input  wire logic       rd_flux_i,
  output logic            rd_bitclk_o,
  output logic            rd_lock_o,
  output logic            rd_field_o,
  output logic            rd_mark_o,
  output logic [7:0]      rd_byte_o,
  output logic            rd_valid_o,
  output logic            rd_err_o,
  input  wire logic [6:0] want_track_i,
  input  wire logic [6:0] want_sector_i,
  output logic            hdr_match_o,
  input  wire logic       door_open_i,
  output logic            door_open_o,
  output logic            disk_in_o,
  input  wire logic [6:0] track_i,
  output logic [2:0]      zone_o,
  output logic [4:0]      sectors_o,
  input  wire logic       tach_i,
  output logic [7:0]      speed_o
);
  // Pin synchronisers
  logic [1:0] wp_sync_reg, flux_sync_reg, door_sync_reg, tach_sync_reg;
  logic       flux_prev_reg, door_prev_reg, tach_prev_reg;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_sync_reg   <= 2'h3;
      flux_sync_reg <= 2'h0;
      door_sync_reg <= 2'h3;
      tach_sync_reg <= 2'h0;
      flux_prev_reg <= 1'b0;
      door_prev_reg <= 1'b1;
      tach_prev_reg <= 1'b0;
    end else begin
      wp_sync_reg   <= {wp_sync_reg[0], wr_prot_i};
      flux_sync_reg <= {flux_sync_reg[0], rd_flux_i};
      door_sync_reg <= {door_sync_reg[0], door_open_i};
      tach_sync_reg <= {tach_sync_reg[0], tach_i};
      flux_prev_reg <= flux_sync_reg[1];
      door_prev_reg <= door_sync_reg[1];
      tach_prev_reg <= tach_sync_reg[1];
    end
  end

  wire wp_s      = wp_sync_reg[1];
  wire flux_edge = flux_sync_reg[1] & ~flux_prev_reg;
  wire tach_edge = tach_sync_reg[1] & ~tach_prev_reg;

  // Code table lookups: encode for writing, decode for reading
  wr_state_t  wr_state_reg, wr_state_next;
  logic [9:0] rd_sh_reg;
  logic       wr_field_reg;
  wire  [7:0] enc_byte = (wr_state_reg == W_SYNC) ?
                         (wr_field_reg ? MARK_DATA : MARK_HDR) : wr_byte_i;
  logic [4:0] code_hi, code_lo;
  logic [3:0] nib_hi, nib_lo;
  logic       ok_hi, ok_lo;

  gcr_code_rom u_rom_hi (
    .nib_i   (enc_byte[7:4]),
    .code_i  (rd_sh_reg[9:5]),
    .code_o  (code_hi),
    .nib_o   (nib_hi),
    .valid_o (ok_hi)
  );

  gcr_code_rom u_rom_lo (
    .nib_i   (enc_byte[3:0]),
    .code_i  (rd_sh_reg[4:0]),
    .code_o  (code_lo),
    .nib_o   (nib_lo),
    .valid_o (ok_lo)
  );

  // Write serialiser
  logic [3:0] wr_cell_reg, wr_bit_reg;
  logic [9:0] wr_sh_reg;
  logic       wr_gate_reg, wr_dout_reg;
  wire        wr_tick  = (wr_state_reg != W_IDLE) && (wr_cell_reg == CELL_LAST);
  wire        grp_end  = wr_tick && (wr_bit_reg == GROUP_LAST);
  wire        take     = grp_end && (wr_state_reg != W_SYNC) && wr_valid_i;
  wire        load_grp = (grp_end && (wr_state_reg == W_SYNC)) || take;

  assign wr_ready_o = take;
  assign wr_busy_o  = (wr_state_reg != W_IDLE);

  always_comb begin
    wr_state_next = wr_state_reg;
    unique case (wr_state_reg)
      W_IDLE: if (wr_start_i) wr_state_next = W_SYNC;
      W_SYNC: if (grp_end) wr_state_next = W_MARK;
      W_MARK,
      W_DATA: if (grp_end) wr_state_next = wr_valid_i ? W_DATA : W_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_state_reg <= W_IDLE;
      wr_field_reg <= 1'b0;
      wr_cell_reg  <= 4'h0;
      wr_bit_reg   <= 4'h0;
      wr_sh_reg    <= 10'h000;
      wr_gate_reg  <= 1'b0;
      wr_dout_reg  <= 1'b0;
    end else begin
      wr_state_reg <= wr_state_next;
      if (wr_state_reg == W_IDLE && wr_start_i) begin
        wr_field_reg <= wr_field_i;
        wr_sh_reg    <= SYNC_GROUP;
        wr_cell_reg  <= 4'h0;
        wr_bit_reg   <= 4'h0;
      end else if (wr_tick) begin
        wr_cell_reg <= 4'h0;
        wr_bit_reg  <= grp_end ? 4'h0 : wr_bit_reg + 4'h1;
        wr_sh_reg   <= load_grp ? {code_hi, code_lo} : {wr_sh_reg[8:0], 1'b0};
      end else if (wr_state_reg != W_IDLE) begin
        wr_cell_reg <= wr_cell_reg + 4'h1;
      end
      wr_gate_reg <= (wr_state_reg != W_IDLE) && !wp_s;
      wr_dout_reg <= (wr_state_reg != W_IDLE) && !wp_s && wr_sh_reg[9];
    end
  end

  assign wr_gate_o = wr_gate_reg;
  assign wr_data_o = wr_dout_reg;

  // Read clock recovery: each flux edge recentres the cell counter
  logic [3:0] rd_cell_reg, rd_ones_reg, rd_cnt_reg;
  logic       rd_seen_reg, rd_tick_reg, rd_lock_reg, rd_mark_exp_reg, rd_grp_reg;
  wire        rd_tick  = (rd_cell_reg == CELL_LAST) && !flux_edge;
  wire        rd_bit   = rd_seen_reg;
  wire        sync_end = rd_tick && !rd_bit && (rd_ones_reg >= SYNC_MIN);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_cell_reg <= 4'h0;
      rd_seen_reg <= 1'b0;
      rd_tick_reg <= 1'b0;
      rd_ones_reg <= 4'h0;
    end else begin
      rd_tick_reg <= rd_tick;
      if (flux_edge) begin
        rd_cell_reg <= CELL_HALF;
        rd_seen_reg <= 1'b1;
      end else if (rd_tick) begin
        rd_cell_reg <= 4'h0;
        rd_seen_reg <= 1'b0;
      end else begin
        rd_cell_reg <= rd_cell_reg + 4'h1;
      end
      if (rd_tick)
        rd_ones_reg <= !rd_bit ? 4'h0 : (rd_ones_reg == 4'hf) ? 4'hf : rd_ones_reg + 4'h1;
    end
  end

  // Framing: a run of ones, then the first zero opens the mark group
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_lock_reg     <= 1'b0;
      rd_mark_exp_reg <= 1'b0;
      rd_cnt_reg      <= 4'h0;
      rd_sh_reg       <= 10'h000;
      rd_grp_reg      <= 1'b0;
    end else begin
      rd_grp_reg <= 1'b0;
      if (sync_end) begin
        rd_lock_reg     <= 1'b1;
        rd_mark_exp_reg <= 1'b1;
        rd_sh_reg       <= 10'h000;
        rd_cnt_reg      <= 4'h1;
      end else if (rd_tick && rd_lock_reg) begin
        rd_sh_reg  <= {rd_sh_reg[8:0], rd_bit};
        rd_cnt_reg <= (rd_cnt_reg == GROUP_LAST) ? 4'h0 : rd_cnt_reg + 4'h1;
        rd_grp_reg <= (rd_cnt_reg == GROUP_LAST);
        if (rd_bit && rd_ones_reg >= SYNC_MIN)
          rd_lock_reg <= 1'b0;
      end
      if (rd_grp_reg)
        rd_mark_exp_reg <= 1'b0;
    end
  end

  // Byte rebuild and field identification
  wire [7:0] rd_dec   = {nib_hi, nib_lo};
  wire       rd_bad   = !(ok_hi && ok_lo);
  wire       is_data  = (rd_dec == MARK_DATA);
  wire       is_hdr   = (rd_dec == MARK_HDR);
  logic [1:0] hdr_idx_reg;
  logic       trk_ok_reg, rd_field_reg, rd_mark_reg, rd_valid_reg, rd_err_reg, hdr_hit_reg;
  logic [7:0] rd_byte_reg;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_field_reg <= 1'b0;
      rd_mark_reg  <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_err_reg   <= 1'b0;
      rd_byte_reg  <= 8'h00;
      hdr_idx_reg  <= 2'h0;
      trk_ok_reg   <= 1'b0;
      hdr_hit_reg  <= 1'b0;
    end else begin
      rd_mark_reg  <= 1'b0;
      rd_valid_reg <= 1'b0;
      hdr_hit_reg  <= 1'b0;
      if (rd_grp_reg && rd_mark_exp_reg) begin
        rd_mark_reg  <= 1'b1;
        rd_field_reg <= is_data;
        rd_err_reg   <= rd_bad || !(is_data || is_hdr);
        hdr_idx_reg  <= 2'h0;
      end else if (rd_grp_reg) begin
        rd_valid_reg <= 1'b1;
        rd_byte_reg  <= rd_dec;
        rd_err_reg   <= rd_bad;
        if (!rd_field_reg && hdr_idx_reg != 2'h2) begin
          hdr_idx_reg <= hdr_idx_reg + 2'h1;
          if (hdr_idx_reg == 2'h0)
            trk_ok_reg <= (rd_dec == {1'b0, want_track_i});
          else
            hdr_hit_reg <= trk_ok_reg && (rd_dec == {1'b0, want_sector_i}) && !rd_bad;
        end
      end
    end
  end

  assign rd_bitclk_o = rd_tick_reg;
  assign rd_lock_o   = rd_lock_reg;
  assign rd_field_o  = rd_field_reg;
  assign rd_mark_o   = rd_mark_reg;
  assign rd_valid_o  = rd_valid_reg;
  assign rd_err_o    = rd_err_reg;
  assign rd_byte_o   = rd_byte_reg;
  assign hdr_match_o = hdr_hit_reg;

  // Door switch; a closing door signals a fresh diskette
  logic door_reg, disk_in_reg;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      door_reg    <= 1'b1;
      disk_in_reg <= 1'b0;
    end else begin
      door_reg    <= door_sync_reg[1];
      disk_in_reg <= door_prev_reg && !door_sync_reg[1];
    end
  end
  assign door_open_o = door_reg;
  assign disk_in_o   = disk_in_reg;

  // Zones: tracks beyond the innermost are clamped
  wire [6:0] trk_c   = (track_i > TRACK_MAX) ? TRACK_MAX : track_i;
  wire [9:0] trk_x8  = {trk_c, 3'h0};
  wire [2:0] zone    = 3'(trk_x8 / TRACK_COUNT);
  assign zone_o      = zone;
  assign sectors_o   = SECT_OUTER - {2'h0, zone};

  // Speed loop: inner zones spin slower, so their tach period is longer
  logic [19:0] period_reg;
  logic [7:0]  speed_reg;
  wire  [19:0] target = 20'(TACH_BASE) + 20'(TACH_STEP) * {17'h0, zone};
  wire         slow   = period_reg > target;
  wire         fast   = period_reg < target;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      period_reg <= 20'h00000;
      speed_reg  <= SPEED_RESET;
    end else begin
      if (tach_edge) begin
        period_reg <= 20'h00000;
        if (slow && speed_reg != SPEED_MAX)
          speed_reg <= speed_reg + 8'h01;
        else if (fast && speed_reg != SPEED_MIN)
          speed_reg <= speed_reg - 8'h01;
      end else if (period_reg != PERIOD_MAX) begin
        period_reg <= period_reg + 20'h00001;
      end
    end
  end
  assign speed_o = speed_reg;

  // Checks
  a_wp_no_current: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wp_s |=> !wr_gate_o) else $error("write current while protected");
  a_sync_first: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (wr_state_reg == W_IDLE && wr_start_i) |=> (wr_state_reg == W_SYNC) && wr_sh_reg == SYNC_GROUP)
    else $error("field not led by sync");
  a_cell_spacing: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (wr_tick && wr_state_next != W_IDLE) |=> !wr_tick [*7] ##1 wr_tick)
    else $error("bit cell length wrong");
  a_enc_load: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    take |=> wr_sh_reg == {GCR_ENC[$past(wr_byte_i[7:4])], GCR_ENC[$past(wr_byte_i[3:0])]})
    else $error("encoded group wrong");
  a_sync_lock: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    sync_end |=> rd_lock_o ##[1:90] rd_mark_o) else $error("sync did not lock");
  a_byte_pulse: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_valid_o |=> !rd_valid_o [*7]) else $error("byte strobes too close");
  a_zone_sectors: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (track_i == 7'h00 |-> sectors_o == SECT_OUTER) and
    (track_i == TRACK_MAX |-> sectors_o == SECT_INNER)) else $error("sector count wrong");
  a_speed_up: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (tach_edge && slow && speed_o != SPEED_MAX) |=> speed_o == $past(speed_o) + 8'h01)
    else $error("speed not raised");
  a_door_insert: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $fell(door_sync_reg[1]) |=> disk_in_o ##1 !disk_in_o) else $error("insert not reported");
endmodule // gcr_disk_data_codec

// >>> hdl/gcr_codec_pkg.sv
// Shared constants and types for the group-code disk data path
package gcr_codec_pkg;
  localparam int unsigned CLK_MHZ      = 40;
  localparam int unsigned BIT_CELL_NS  = 200;
  localparam int unsigned BIT_CELL_CYC = BIT_CELL_NS * CLK_MHZ / 1000;
  localparam logic [3:0]  CELL_LAST    = 4'(BIT_CELL_CYC - 1);
  localparam logic [3:0]  CELL_HALF    = 4'(BIT_CELL_CYC / 2);
  localparam logic [3:0]  GROUP_LAST   = 4'h9;
  localparam logic [9:0]  SYNC_GROUP   = 10'h3ff;
  localparam logic [3:0]  SYNC_MIN     = 4'h9;
  localparam logic [7:0]  MARK_HDR     = 8'h07;
  localparam logic [7:0]  MARK_DATA    = 8'h08;
  localparam logic [6:0]  TRACK_MAX    = 7'h50;
  localparam logic [9:0]  TRACK_COUNT  = 10'h051;
  localparam logic [4:0]  SECT_OUTER   = 5'h13;
  localparam logic [4:0]  SECT_INNER   = 5'h0c;
  localparam int unsigned TACH_BASE_US = 1000;
  localparam int unsigned TACH_STEP_US = 100;
  localparam int unsigned TACH_BASE_CYC = TACH_BASE_US * CLK_MHZ;
  localparam int unsigned TACH_STEP_CYC = TACH_STEP_US * CLK_MHZ;
  localparam logic [7:0]  SPEED_RESET  = 8'h80;
  localparam logic [7:0]  SPEED_MAX    = 8'hff;
  localparam logic [7:0]  SPEED_MIN    = 8'h00;
  localparam logic [19:0] PERIOD_MAX   = 20'hfffff;
  localparam logic [4:0]  GCR_ENC [16] = '{
    5'h0a, 5'h0b, 5'h12, 5'h13, 5'h0e, 5'h0f, 5'h16, 5'h17,
    5'h09, 5'h19, 5'h1a, 5'h1b, 5'h0d, 5'h1d, 5'h1e, 5'h15};

  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_SYNC = 2'b01,
    W_MARK = 2'b10,
    W_DATA = 2'b11
  } wr_state_t;
endpackage

// >>> hdl/gcr_code_rom.sv
// Fixed nibble to group-code table, both directions
module gcr_code_rom
  import gcr_codec_pkg::*;
(
  input  wire logic [3:0] nib_i,
  input  wire logic [4:0] code_i,
  output logic      [4:0] code_o,
  output logic      [3:0] nib_o,
  output logic            valid_o
);
  assign code_o = GCR_ENC[nib_i];

  always_comb begin
    nib_o   = 4'h0;
    valid_o = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (GCR_ENC[i] == code_i) begin
        nib_o   = 4'(i);
        valid_o = 1'b1;
      end
    end
  end
endmodule // gcr_code_rom

// >>> dv/disk_head_model.sv
// Drive-side model: flux pulses from the read head and motor tach pulses
module disk_head_model
  import gcr_codec_pkg::*;
(
  input  wire logic clk_i,
  output logic      flux_o,
  output logic      tach_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    flux_o = 1'b0;
    tach_o = 1'b0;
  end

  // One cell; a zero leaves the line quiet, so clock recovery must coast
  task automatic send_cell(input logic bit_v);
    @(negedge clk_i);
    flux_o = bit_v;
    @(negedge clk_i);
    flux_o = 1'b0;
    repeat (BIT_CELL_CYC - 2) @(negedge clk_i);
  endtask

  task automatic send_group(input logic [9:0] g);
    for (int i = 9; i >= 0; i--) begin
      send_cell(g[i]);
    end
  endtask

  // Longer than one group of ones so lock is reached with margin
  task automatic send_sync();
    repeat (12) send_cell(1'b1);
  endtask

  task automatic tach_run(input int period, input int n);
    repeat (n) begin
      @(negedge clk_i);
      tach_o = 1'b1;
      repeat (2) @(negedge clk_i);
      tach_o = 1'b0;
      repeat (period - 3) @(negedge clk_i);
    end
  endtask
endmodule  // disk_head_model

// >>> dv/gcr_disk_data_codec_tb.sv
// Self-checking bench for the group-code disk data path
module gcr_disk_data_codec_tb;
  import gcr_codec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [4:0] enc_tab [16] = '{5'h0a, 5'h0b, 5'h12, 5'h13, 5'h0e, 5'h0f, 5'h16,
    5'h17, 5'h09, 5'h19, 5'h1a, 5'h1b, 5'h0d, 5'h1d, 5'h1e, 5'h15};

  logic       clk_sys_i = 1'b0, arst_n_i = 1'b0, wr_start_i = 1'b0, wr_field_i = 1'b0;
  logic       wr_valid_i = 1'b0, wr_prot_i = 1'b0, door_open_i = 1'b1;
  logic [7:0] wr_byte_i = 8'h00;
  logic [6:0] want_track_i = 7'h00, want_sector_i = 7'h00, track_i = 7'h00;
  logic       rd_flux_i, tach_i, wr_ready_o, wr_busy_o, wr_gate_o, wr_data_o, rd_bitclk_o;
  logic       rd_lock_o, rd_field_o, rd_mark_o, rd_valid_o, rd_err_o, hdr_match_o;
  logic       door_open_o, disk_in_o;
  logic [7:0] rd_byte_o, speed_o, spd;
  logic [2:0] zone_o;
  logic [4:0] sectors_o;
  logic [8:0] rx_q [$];
  logic [1:0] mark_seen;
  logic [7:0] q [$];
  logic [6:0] t;
  int         n_mismatch = 0, samples_checked = 0, n_ready = 0, n_mark = 0, n_match = 0;
  int         n_bclk = 0;
  integer     seed = 32'h798fab28;

  always #12.5 clk_sys_i = ~clk_sys_i;

  gcr_disk_data_codec #(.TACH_BASE(40), .TACH_STEP(4)) dut_u (
    .clk_sys_i, .arst_n_i, .wr_start_i, .wr_field_i, .wr_byte_i, .wr_valid_i, .wr_ready_o,
    .wr_busy_o, .wr_prot_i, .wr_gate_o, .wr_data_o, .rd_flux_i, .rd_bitclk_o, .rd_lock_o,
    .rd_field_o, .rd_mark_o, .rd_byte_o, .rd_valid_o, .rd_err_o, .want_track_i,
    .want_sector_i, .hdr_match_o, .door_open_i, .door_open_o, .disk_in_o, .track_i,
    .zone_o, .sectors_o, .tach_i, .speed_o);

  disk_head_model head_u (.clk_i(clk_sys_i), .flux_o(rd_flux_i), .tach_o(tach_i));

  always @(posedge clk_sys_i) begin
    if (wr_ready_o === 1'b1) n_ready++;
    if (rd_bitclk_o === 1'b1) n_bclk++;
    if (rd_valid_o === 1'b1) rx_q.push_back({rd_err_o, rd_byte_o});
    if (rd_mark_o === 1'b1) begin
      n_mark++;
      mark_seen = {rd_err_o, rd_field_o};
    end
    if (hdr_match_o === 1'b1) n_match++;
  end

  function automatic logic [9:0] enc(input logic [7:0] b);
    return {enc_tab[b[7:4]], enc_tab[b[3:0]]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Samples mid-cell; a second start mid-field must be ignored
  task automatic write_field(input logic fld, input logic [7:0] b, input logic prot);
    logic [29:0] exp_bits;
    int          rdy0;
    exp_bits = prot ? 30'h0 : {10'h3ff, enc(fld ? 8'h08 : 8'h07), enc(b)};
    rdy0 = n_ready;
    wr_prot_i = prot;
    wr_field_i = fld;
    wr_byte_i = b;
    wr_valid_i = 1'b1;
    wr_start_i = 1'b1;
    @(negedge clk_sys_i);
    wr_start_i = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    for (int i = 29; i >= 0; i--) begin
      check(wr_data_o, exp_bits[i]);
      check(wr_gate_o, !prot);
      check(wr_busy_o, 1'b1);
      wr_start_i = (i == 17);
      if (i == 9) wr_valid_i = 1'b0;
      repeat (8) @(negedge clk_sys_i);
    end
    check(n_ready - rdy0, 1);
    for (int n = 0; n < 100 && wr_busy_o !== 1'b0; n++) @(negedge clk_sys_i);
    check(wr_busy_o, 1'b0);
    if (wr_busy_o !== 1'b0) complete_run();
  endtask

  task automatic read_frame(input logic fld, input logic bad);
    head_u.send_sync();
    // Cleared late: a group of five quiet cells and five sync ones after the last frame lands during sync
    rx_q.delete();
    n_mark = 0;
    n_match = 0;
    head_u.send_group(enc(fld ? 8'h08 : 8'h07));
    foreach (q[i]) head_u.send_group(enc(q[i]));
    // Invalid high half without a long run of ones, so no false sync follows
    if (bad) head_u.send_group(10'h00a);
    n_bclk = 0;
    repeat (40) @(negedge clk_sys_i);
    check(n_bclk, 5);
    check(rd_lock_o, 1'b1);
    check(n_mark, 1);
    check(mark_seen, {1'b0, fld});
    check(rx_q.size(), q.size() + bad);
    foreach (q[i]) if (i < rx_q.size()) check(rx_q[i], {1'b0, q[i]});
    if (bad && rx_q.size() > 0) check(rx_q[rx_q.size() - 1][8], 1'b1);
  endtask

  initial begin
    repeat (8) @(negedge clk_sys_i);
    check(speed_o, 8'h80);
    check(door_open_o, 1'b1);
    arst_n_i = 1'b1;
    // Clamp above the last track is the corner case here
    for (int i = 0; i < 12; i++) begin
      t = (i == 0) ? 7'h00 : (i == 1) ? 7'h50 : (i == 2) ? 7'h7f : 7'($unsigned($random(seed)) % 81);
      track_i = t;
      @(negedge clk_sys_i);
      check(zone_o, ((t > 80 ? 80 : t) * 8) / 81);
      check(sectors_o, 19 - ((t > 80 ? 80 : t) * 8) / 81);
    end
    for (int i = 0; i < 8; i++) begin
      write_field(i[0], {4'(i), 4'(15 - i)}, 1'b0);
    end
    write_field(1'b1, 8'($random(seed)), 1'b1);
    for (int i = 0; i < 16; i++) q.push_back({4'(i), 4'(15 - i)});
    read_frame(1'b1, 1'b0);
    for (int k = 0; k < 2; k++) begin
      want_track_i = 7'($unsigned($random(seed)) % 81);
      want_sector_i = 7'($unsigned($random(seed)) % 19);
      q = '{{1'b0, want_track_i}, {1'b0, want_sector_i ^ 7'(k)}, 8'($random(seed))};
      read_frame(1'b0, 1'b0);
      check(n_match, 1 - k);
    end
    q = '{8'($random(seed)), 8'($random(seed))};
    read_frame(1'b1, 1'b1);
    door_open_i = 1'b0;
    for (int n = 0; n < 10 && disk_in_o !== 1'b1; n++) @(negedge clk_sys_i);
    check(disk_in_o, 1'b1);
    @(negedge clk_sys_i);
    check(door_open_o, 1'b0);
    track_i = 7'h00;
    head_u.tach_run(60, 6);
    check(speed_o > 8'h80, 1'b1);
    spd = speed_o;
    head_u.tach_run(30, 6);
    check(speed_o < spd, 1'b1);
    complete_run();
  end
endmodule  // gcr_disk_data_codec_tb
